/* hdl/eeprom_loader_pkg.sv */
package eeprom_loader_pkg;

  // ****************************************
  // Widths and register offsets
  // ****************************************
  localparam int          WORD_W            = 16;
  localparam int          IDX_W             = 4;
  localparam int          ROM_ADDR_W        = 6;
  localparam int          ROM_WORD_COUNT    = 16;
  localparam logic [7:0]  WRITE_PORT_OFFSET = 8'h14;

  // ****************************************
  // Write port field layout
  // ****************************************
  localparam int          VALUE_MSB         = 31;
  localparam int          VALUE_LSB         = 16;
  localparam int          INDEX_MSB         = 15;
  localparam int          INDEX_LSB         = 12;
  localparam int          COMMIT_BIT        = 8;

  // ****************************************
  // Configuration word zero fields and reset values
  // ****************************************
  localparam int          IDLE_POWER_BIT    = 15;
  localparam int          REVISION_BIT      = 9;
  localparam int          WAKE_BIT          = 4;
  localparam int          VENDOR_BIT        = 3;
  localparam int          DIAG_BIT          = 2;
  localparam int          SWAP_BIT          = 1;
  localparam int          EXPROM_BIT        = 0;
  localparam logic [15:0] WORD0_RESET       = 16'h0007;
  localparam logic [15:0] WORDN_RESET       = 16'h0000;
  localparam logic [15:0] ROM_ABSENT_WORD   = 16'hffff;

  // ****************************************
  // Serial memory timing and command
  // ****************************************
  localparam int          CORE_CLK_NS       = 10;
  localparam int          ROM_SK_HALF_NS    = 500;
  localparam int          ROM_SK_HALF_CYC   = (ROM_SK_HALF_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int          DIV_W             = 8;
  localparam logic [2:0]  ROM_READ_OP       = 3'h6;
  localparam int          ROM_CMD_BITS      = 9;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic        strobe;
    logic [7:0]  offset;
    logic [31:0] data;
  } cfg_write_s;

  typedef struct packed {
    logic idle_power_save;
    logic host_if_revision_select;
    logic wake_signal_enable;
    logic vendor_code_select;
    logic diag_access_enable;
    logic rom_byte_swap;
    logic expansion_rom_flag;
  } word0_flags_s;

  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } rom_pins_s;

  typedef enum logic [3:0] {
    R_IDLE  = 4'h1,
    R_SHIFT = 4'h2,
    R_READ  = 4'h4,
    R_DONE  = 4'h8
  } rd_state_e;

  typedef enum logic [2:0] {
    T_LOAD = 3'h1,
    T_WAIT = 3'h2,
    T_RUN  = 3'h4
  } top_state_e;

endpackage : eeprom_loader_pkg

/* hdl/serial_rom_reader.sv */
`timescale 1ns/1ps
module serial_rom_reader (
  input  wire logic                                    core_clk,
  input  wire logic                                    rst_n,
  input  wire logic                                    start,
  input  wire logic [eeprom_loader_pkg::ROM_ADDR_W-1:0] addr,
  input  wire logic                                    serial_rom_data_out,
  output logic                                         done,
  output logic [15:0]                                  data,
  output eeprom_loader_pkg::rom_pins_s                 pins
);

  typedef struct packed {
    eeprom_loader_pkg::rd_state_e  st;
    logic [eeprom_loader_pkg::DIV_W-1:0] div;
    logic [4:0]                    bits;
    logic [8:0]                    cmd;
    logic [15:0]                   shreg;
    eeprom_loader_pkg::rom_pins_s  pins;
    logic                          done;
    logic                          sync1;
    logic                          sync2;
  } rd_state_s;

  rd_state_s s_reg;
  rd_state_s s_next;
  logic      tick;

  // Half period of the serial clock elapsed
  assign tick = (s_reg.div == eeprom_loader_pkg::DIV_W'(eeprom_loader_pkg::ROM_SK_HALF_CYC - 1));

  // Command shift, then sixteen data bits sampled on rising serial clock
  always_comb begin
    s_next       = s_reg;
    s_next.done  = 1'b0;
    s_next.sync1 = serial_rom_data_out;
    s_next.sync2 = s_reg.sync1;
    if (s_reg.st == eeprom_loader_pkg::R_SHIFT || s_reg.st == eeprom_loader_pkg::R_READ) begin
      s_next.div = tick ? '0 : s_reg.div + 1'b1;
    end
    unique case (s_reg.st)
      eeprom_loader_pkg::R_IDLE: begin
        if (start) begin
          s_next.st      = eeprom_loader_pkg::R_SHIFT;
          s_next.cmd     = {eeprom_loader_pkg::ROM_READ_OP, addr};
          s_next.pins.cs = 1'b1;
          s_next.pins.sk = 1'b0;
          s_next.pins.di = eeprom_loader_pkg::ROM_READ_OP[2];
          s_next.bits    = '0;
          s_next.div     = '0;
        end
      end
      eeprom_loader_pkg::R_SHIFT: begin
        if (tick && !s_reg.pins.sk) begin
          s_next.pins.sk = 1'b1;
        end else if (tick) begin
          s_next.pins.sk = 1'b0;
          if (s_reg.bits == 5'(eeprom_loader_pkg::ROM_CMD_BITS - 1)) begin
            s_next.st      = eeprom_loader_pkg::R_READ;
            s_next.bits    = '0;
            s_next.pins.di = 1'b0;
          end else begin
            s_next.cmd     = {s_reg.cmd[7:0], 1'b0};
            s_next.pins.di = s_reg.cmd[7];
            s_next.bits    = s_reg.bits + 5'h01;
          end
        end
      end
      eeprom_loader_pkg::R_READ: begin
        if (tick && !s_reg.pins.sk) begin
          s_next.pins.sk = 1'b1;
          s_next.shreg   = {s_reg.shreg[14:0], s_reg.sync2};
        end else if (tick) begin
          s_next.pins.sk = 1'b0;
          if (s_reg.bits == 5'h0f) begin
            s_next.st      = eeprom_loader_pkg::R_DONE;
            s_next.pins.cs = 1'b0;
            s_next.done    = 1'b1;
          end else begin
            s_next.bits = s_reg.bits + 5'h01;
          end
        end
      end
      eeprom_loader_pkg::R_DONE: begin
        s_next.st = eeprom_loader_pkg::R_IDLE;
      end
      default: begin
        s_next.st = eeprom_loader_pkg::R_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg    <= '0;
      s_reg.st <= eeprom_loader_pkg::R_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign data = s_reg.shreg;
  assign pins = s_reg.pins;

endmodule : serial_rom_reader

/* hdl/eeprom_config_loader.sv */
`timescale 1ns/1ps
module eeprom_config_loader #(
  parameter int WORDS = eeprom_loader_pkg::ROM_WORD_COUNT
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire eeprom_loader_pkg::cfg_write_s cfg_wr,
  input  wire logic                          pme_req,
  input  wire logic                          serial_rom_data_out,
  output eeprom_loader_pkg::rom_pins_s       rom_pins,
  output eeprom_loader_pkg::word0_flags_s    flags,
  output logic [WORDS*16-1:0]                cfg_words,
  output logic                               load_done,
  output logic                               pme_o,
  output logic                               pme_oe
);

  // ****************************************
  // State and helpers
  // ****************************************
  typedef struct packed {
    eeprom_loader_pkg::top_state_e   state;
    logic [eeprom_loader_pkg::IDX_W-1:0] idx;
    logic [WORDS-1:0][15:0]          words;
    logic                            locked;
    logic                            rd_start;
    logic                            load_done;
    eeprom_loader_pkg::word0_flags_s flags;
    logic                            pme_o;
    logic                            pme_oe;
  } top_state_s;

  top_state_s  s_reg;
  top_state_s  s_next;
  logic        rd_done;
  logic [15:0] rd_data;
  logic        wr_hit;
  logic        wr_take;
  logic [eeprom_loader_pkg::IDX_W-1:0] wr_idx;
  logic [15:0] wr_value;

  // Split word zero into its control flags
  function automatic eeprom_loader_pkg::word0_flags_s decode_word0(input logic [15:0] w);
    eeprom_loader_pkg::word0_flags_s f;
    f.idle_power_save         = w[eeprom_loader_pkg::IDLE_POWER_BIT];
    f.host_if_revision_select = w[eeprom_loader_pkg::REVISION_BIT];
    f.wake_signal_enable      = w[eeprom_loader_pkg::WAKE_BIT];
    f.vendor_code_select      = w[eeprom_loader_pkg::VENDOR_BIT];
    f.diag_access_enable      = w[eeprom_loader_pkg::DIAG_BIT];
    f.rom_byte_swap           = w[eeprom_loader_pkg::SWAP_BIT];
    f.expansion_rom_flag      = w[eeprom_loader_pkg::EXPROM_BIT];
    return f;
  endfunction : decode_word0

  // ****************************************
  // Serial memory reader
  // ****************************************
  serial_rom_reader u_reader (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .start               (s_reg.rd_start),
    .addr                (eeprom_loader_pkg::ROM_ADDR_W'(s_reg.idx)),
    .serial_rom_data_out (serial_rom_data_out),
    .done                (rd_done),
    .data                (rd_data),
    .pins                (rom_pins)
  );

  // Write port decode
  assign wr_hit   = cfg_wr.strobe && (cfg_wr.offset == eeprom_loader_pkg::WRITE_PORT_OFFSET);
  assign wr_idx   = cfg_wr.data[eeprom_loader_pkg::INDEX_MSB:eeprom_loader_pkg::INDEX_LSB];
  assign wr_value = cfg_wr.data[eeprom_loader_pkg::VALUE_MSB:eeprom_loader_pkg::VALUE_LSB];
  assign wr_take  = wr_hit && cfg_wr.data[eeprom_loader_pkg::COMMIT_BIT]
                    && s_reg.words[0][eeprom_loader_pkg::DIAG_BIT]
                    && !s_reg.locked && (s_reg.state == eeprom_loader_pkg::T_RUN)
                    && (32'(wr_idx) < WORDS);

  // ****************************************
  // Load sequence and write port
  // ****************************************
  always_comb begin
    s_next          = s_reg;
    s_next.rd_start = 1'b0;
    s_next.flags    = decode_word0(s_reg.words[0]);
    s_next.pme_o    = 1'b0;
    s_next.pme_oe   = pme_req && s_reg.flags.wake_signal_enable;
    unique case (s_reg.state)
      eeprom_loader_pkg::T_LOAD: begin
        s_next.rd_start = 1'b1;
        s_next.state    = eeprom_loader_pkg::T_WAIT;
      end
      eeprom_loader_pkg::T_WAIT: begin
        if (rd_done) begin
          if (s_reg.idx == '0 && rd_data == eeprom_loader_pkg::ROM_ABSENT_WORD) begin
            s_next.state     = eeprom_loader_pkg::T_RUN;
            s_next.load_done = 1'b1;
          end else begin
            s_next.words[s_reg.idx] = rd_data;
            if (32'(s_reg.idx) == WORDS - 1) begin
              s_next.state     = eeprom_loader_pkg::T_RUN;
              s_next.load_done = 1'b1;
            end else begin
              s_next.idx   = s_reg.idx + 1'b1;
              s_next.state = eeprom_loader_pkg::T_LOAD;
            end
          end
        end
      end
      eeprom_loader_pkg::T_RUN: begin
        if (wr_take) begin
          s_next.words[wr_idx] = wr_value;
          if (wr_idx == '0 && !wr_value[eeprom_loader_pkg::DIAG_BIT]) begin
            s_next.locked = 1'b1;
          end
        end
      end
      default: begin
        s_next.state = eeprom_loader_pkg::T_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.state    <= eeprom_loader_pkg::T_LOAD;
      s_reg.words[0] <= eeprom_loader_pkg::WORD0_RESET;
      s_reg.flags    <= decode_word0(eeprom_loader_pkg::WORD0_RESET);
    end else begin
      s_reg <= s_next;
    end
  end

  assign flags     = s_reg.flags;
  assign cfg_words = s_reg.words;
  assign load_done = s_reg.load_done;
  assign pme_o     = s_reg.pme_o;
  assign pme_oe    = s_reg.pme_oe;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  load_copy_a: assert property (s_reg.state == eeprom_loader_pkg::T_WAIT && rd_done &&
      s_reg.idx == 4'h1 |=> s_reg.words[1] == $past(rd_data))
    else $error("loaded word one differs from memory data");
  absent_keep_a: assert property (s_reg.state == eeprom_loader_pkg::T_WAIT && rd_done &&
      s_reg.idx == 4'h0 && rd_data == 16'hffff |=> s_reg.words[0] == 16'h0007 && load_done)
    else $error("absent memory altered word zero");
  idle_power_a: assert property (##1 s_reg.words[0][15] |=> flags.idle_power_save)
    else $error("idle power flag not following word zero");
  revision_sel_a: assert property ($changed(s_reg.words[0][9])
      |=> flags.host_if_revision_select == $past(s_reg.words[0][9]))
    else $error("revision select not following word zero");
  wake_gate_a: assert property (pme_oe |-> $past(flags.wake_signal_enable) && !pme_o)
    else $error("wake output driven while disabled");
  vendor_swap_rom_a: assert property (##1 s_reg.words[0][3:0] == 4'h0
      |=> !flags.vendor_code_select && !flags.rom_byte_swap && !flags.expansion_rom_flag)
    else $error("word zero flags mis-decoded");
  commit_gate_a: assert property (s_reg.state == eeprom_loader_pkg::T_RUN &&
      wr_hit && !cfg_wr.data[8] |=> $stable(s_reg.words))
    else $error("write without commit bit changed a word");
  diag_gate_a: assert property (s_reg.state == eeprom_loader_pkg::T_RUN &&
      !s_reg.words[0][2] |=> $stable(s_reg.words))
    else $error("word written with diagnostic access off");
  write_store_a: assert property (wr_take && wr_idx == 4'h0
      |=> s_reg.words[0] == $past(cfg_wr.data[31:16]))
    else $error("port write not stored in word zero");
  lock_set_a: assert property (wr_take && wr_idx == 4'h0 && !cfg_wr.data[18]
      |=> s_reg.locked ##1 $stable(s_reg.words))
    else $error("write port not locked after word zero");

  // ****************************************
  // Refusal and hold checks
  // ****************************************
  // Writes that miss the port or the word range leave every word alone
  offset_skip_a: assert property (s_reg.state == eeprom_loader_pkg::T_RUN &&
      cfg_wr.strobe && cfg_wr.offset != eeprom_loader_pkg::WRITE_PORT_OFFSET
      |=> $stable(s_reg.words))
    else $error("write to another offset changed a word");
  index_range_a: assert property (s_reg.state == eeprom_loader_pkg::T_RUN &&
      wr_hit && 32'(wr_idx) >= WORDS |=> $stable(s_reg.words))
    else $error("write beyond the last word changed a word");
  // Lock and load completion hold until the next reset, and each load step starts a word read
  lock_hold_a: assert property (s_reg.locked
      |=> s_reg.locked && $stable(s_reg.words))
    else $error("locked write port changed a word");
  load_hold_a: assert property (load_done
      |=> load_done && s_reg.state == eeprom_loader_pkg::T_RUN)
    else $error("load finished flag dropped");
  load_order_a: assert property (s_reg.state == eeprom_loader_pkg::T_LOAD
      |=> s_reg.rd_start && s_reg.state == eeprom_loader_pkg::T_WAIT)
    else $error("word read not started after load step");
  // Wake enable is the request gated by word zero, one cycle late
  wake_follow_a: assert property (pme_oe ==
      ($past(pme_req) && $past(flags.wake_signal_enable)))
    else $error("wake output enable not following request");

  // Main scenarios
  load_end_c:   cover property ($rose(load_done));
  absent_c:     cover property (s_reg.state == eeprom_loader_pkg::T_WAIT && rd_done &&
      rd_data == eeprom_loader_pkg::ROM_ABSENT_WORD);
  port_write_c: cover property (wr_take);
  lock_c:       cover property ($rose(s_reg.locked));
  wake_c:       cover property ($rose(pme_oe));

endmodule : eeprom_config_loader

/* sim/serial_rom_model.sv */
`timescale 1ns/1ps
module serial_rom_model (
  input  wire logic        cs,
  input  wire logic        sk,
  input  wire logic        di,
  input  wire logic        present,
  input  wire logic [63:0] image,
  output logic             q,
  output logic             bad_cmd
);
  int          n;
  logic        en;
  logic [8:0]  cmd;
  logic [15:0] word;

  // ************************************
  // Serial read frame
  // ************************************
  // Start state
  initial begin
    n       = 0;
    en      = 1'b0;
    cmd     = '0;
    word    = '0;
    bad_cmd = 1'b0;
  end

  // New frame on select
  always @(posedge cs) begin
    n  = 0;
    en = 1'b0;
  end

  // Command bits in on rising clock, start and opcode checked
  always @(posedge sk) begin
    if (cs && n < 9) cmd = {cmd[7:0], di};
    if (cs) n = n + 1;
    if (cs && n == 9 && cmd[8:6] != 3'h6) bad_cmd = 1'b1;
  end

  // Data out on falling clock, bit 15 first, right after the address
  always @(negedge sk) begin
    if (cs && n == 9) begin
      word = (cmd[5:0] < 6'h04) ? image[16*cmd[5:0] +: 16] : 16'h0000;
      en   = 1'b1;
    end else if (cs && n > 9) begin
      word = {word[14:0], ~word[15]}; // Filler bits are inverted, never stale
    end
  end

  // Released or absent: the pull-up shows
  assign q = (present && cs && en) ? word[15] : 1'b1;
endmodule : serial_rom_model

/* sim/eeprom_config_loader_test.sv */
`timescale 1ns/1ps
module eeprom_config_loader_test;
  logic                          core_clk;
  logic                          rst_n;
  eeprom_loader_pkg::cfg_write_s cfg_wr;
  logic                          pme_req;
  logic                          rom_q;
  logic                          present;
  logic                          bad_cmd;
  eeprom_loader_pkg::rom_pins_s  rom_pins;
  eeprom_loader_pkg::word0_flags_s flags;
  logic [63:0]                   cfg_words;
  logic                          load_done;
  logic                          pme_o;
  logic                          pme_oe;
  int                            errors;
  int                            n_compared;
  localparam logic [63:0]        IMAGE = 64'h5a5a_abcd_1234_8212;

  eeprom_config_loader #(.WORDS(4)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .pme_req(pme_req),
    .serial_rom_data_out(rom_q), .rom_pins(rom_pins), .flags(flags),
    .cfg_words(cfg_words), .load_done(load_done), .pme_o(pme_o), .pme_oe(pme_oe)
  );

  serial_rom_model rom (
    .cs(rom_pins.cs), .sk(rom_pins.sk), .di(rom_pins.di), .present(present),
    .image(IMAGE), .q(rom_q), .bad_cmd(bad_cmd)
  );

  // ************************************
  // Clock and helpers
  // ************************************
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    @(posedge core_clk);
    cfg_wr <= '{strobe: 1'b1, offset: off, data: d};
    @(posedge core_clk);
    cfg_wr.strobe <= 1'b0;
  endtask : wr

  function automatic logic [31:0] pw(input logic [15:0] v, input logic [3:0] i, input logic c);
    return {v, i, 3'h0, c, 8'h00};
  endfunction : pw

  function automatic logic [63:0] fl(input logic [15:0] w);
    return {57'h0, w[15], w[9], w[4], w[3], w[2], w[1], w[0]};
  endfunction : fl

  task automatic reset_and_load;
    int k;
    @(posedge core_clk);
    rst_n <= 1'b0;
    tick(2);
    check(cfg_words, 64'h0007);
    check(64'(flags), fl(16'h0007));
    check({63'h0, load_done}, 64'h0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    k = 0;
    while (load_done !== 1'b1 && k < 15000) begin
      tick(1);
      k++;
    end
    if (k >= 15000) begin
      errors++;
      $display("unexpected at %0t: load never finished", $time);
      conclude();
    end
    tick(3);
  endtask : reset_and_load

  // ************************************
  // Main sequence
  // ************************************
  // Scenarios
  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    cfg_wr = '0;
    pme_req = 1'b0;
    present = 1'b0;
    tick(3);
    // Open data pin: reset values kept, write port in use
    reset_and_load();
    check(cfg_words, 64'h0007);
    wr(8'h14, pw(16'hbeef, 4'h1, 1'b0));
    tick(3);
    check(cfg_words, 64'h0007);
    wr(8'h10, pw(16'hbeef, 4'h1, 1'b1));
    tick(3);
    check(cfg_words, 64'h0007);
    wr(8'h14, pw(16'hbeef, 4'h5, 1'b1));
    tick(3);
    check(cfg_words, 64'h0007);
    wr(8'h14, pw(16'hbeef, 4'h1, 1'b1));
    wr(8'h14, pw(16'hc0de, 4'h2, 1'b1));
    wr(8'h14, pw(16'h820f, 4'h0, 1'b1));
    tick(3);
    check(cfg_words, 64'h0000_c0de_beef_820f);
    check(64'(flags), fl(16'h820f));
    @(posedge core_clk);
    pme_req <= 1'b1;
    tick(3);
    check({62'h0, pme_oe, pme_o}, 64'h0);
    wr(8'h14, pw(16'h0010, 4'h0, 1'b1));
    tick(4);
    check(64'(flags), fl(16'h0010));
    check({62'h0, pme_oe, pme_o}, 64'h2);
    wr(8'h14, pw(16'hffff, 4'h1, 1'b1));
    tick(3);
    check(cfg_words, 64'h0000_c0de_beef_0010);
    $display("test write port done");
    // Memory present: image copied after reset
    present = 1'b1;
    pme_req <= 1'b0;
    reset_and_load();
    check(cfg_words, IMAGE);
    check(64'(flags), fl(16'h8212));
    check({63'h0, bad_cmd}, 64'h0);
    wr(8'h14, pw(16'h7777, 4'h1, 1'b1));
    tick(3);
    check(cfg_words, IMAGE);
    @(posedge core_clk);
    pme_req <= 1'b1;
    tick(3);
    check({62'h0, pme_oe, pme_o}, 64'h2);
    $display("test memory load done");
    conclude();
  end
endmodule : eeprom_config_loader_test
